// ===== logic/dsr_pkg.sv
// Constants shared by the debug status register bank
package dsr_pkg;
   // ------------------------------------------------------------------
   // Register offsets on the processor-status port
   // ------------------------------------------------------------------
   localparam logic [7:0] OFF_TILE_CELL_OSC = 8'h07;  // Tile cell oscillator count
   localparam logic [7:0] OFF_TILE_WIRE_OSC = 8'h08;  // Tile wire oscillator count
   localparam logic [7:0] OFF_PER_CELL_OSC = 8'h09;   // Peripheral cell count
   localparam logic [7:0] OFF_PER_WIRE_OSC = 8'h0A;   // Peripheral wire count
   localparam logic [7:0] OFF_MEMORY_SIZE = 8'h0C;    // On-chip memory size
   localparam logic [7:0] OFF_SSW = 8'h10;            // Saved status word
   localparam logic [7:0] OFF_SPC = 8'h11;            // Saved program counter
   localparam logic [7:0] OFF_SSP = 8'h12;            // Saved stack pointer
   localparam logic [7:0] OFF_RR_THREAD = 8'h13;      // Remote read thread select
   localparam logic [7:0] OFF_RR_REG = 8'h14;         // Remote read register select
   localparam logic [7:0] OFF_CAUSE = 8'h15;          // Debug entry cause
   localparam logic [7:0] OFF_ENTRY_DATA = 8'h16;     // Debug entry data
   localparam logic [7:0] OFF_STOP_MASK = 8'h18;      // Thread stop mask
   localparam logic [7:0] OFF_SCRATCH = 8'h20;        // First of eight scratch words
   localparam logic [7:0] OFF_SCRATCH_LAST = 8'h27;   // Last scratch word

   // ------------------------------------------------------------------
   // Field widths and positions
   // ------------------------------------------------------------------
   localparam int OSC_W = 16;          // Oscillator count width
   localparam int NUM_OSC = 4;         // Number of ring oscillators
   localparam int SSW_W = 11;          // Saved status bits 10:0
   localparam int SSW_DUAL_SEL = 9;    // Dual issue on kernel entry
   localparam int SSW_DUAL_CUR = 8;    // Current issue mode, read only
   localparam logic [10:0] SSW_WR_MASK = 11'h6DF;  // Writable status bits
   localparam int THR_W = 8;           // Thread number width
   localparam int REG_W = 5;           // Register index width
   localparam int CAUSE_W = 3;         // Cause code width
   localparam int BP_W = 2;            // Breakpoint index width
   localparam int NUM_BP = 4;          // Breakpoints per kind
   localparam int CAUSE_THR_LSB = 8;   // Thread field low bit
   localparam int CAUSE_BP_LSB = 16;   // Breakpoint field low bit
   localparam int MEMSZ_LSB = 2;       // Low reserved bits of memory size
   localparam int SCR_DEPTH = 8;       // Scratch words
   localparam int SCR_AW = 3;          // Scratch index width

   // ------------------------------------------------------------------
   // Debug entry causes
   // ------------------------------------------------------------------
   localparam logic [2:0] CAUSE_NONE = 3'h0;    // Reset value
   localparam logic [2:0] CAUSE_HOST = 3'h1;    // Host request over JTAG
   localparam logic [2:0] CAUSE_DEBUG_CALL_INSTRUCTION = 3'h2;   // Debug call instruction
   localparam logic [2:0] CAUSE_IBRK = 3'h3;    // Instruction breakpoint
   localparam logic [2:0] CAUSE_DWATCH = 3'h4;  // Data watchpoint
   localparam logic [2:0] CAUSE_RWATCH = 3'h5;  // Resource watchpoint
endpackage

// ===== logic/dsr_scratch_mem.sv
// Eight-word scratch storage shared by the status and configuration ports
`timescale 1ns/1ps
`default_nettype none
module dsr_scratch_mem #(
   parameter int DEPTH = 8,
   parameter int AW = 3
) (
   input wire logic clk_i,
   input wire logic we_i,
   input wire logic [AW-1:0] waddr_i,
   input wire logic [31:0] wdata_i,
   input wire logic [AW-1:0] raddr_a_i,
   input wire logic [AW-1:0] raddr_b_i,
   output logic [31:0] rdata_a_o,
   output logic [31:0] rdata_b_o
);
   // ------------------------------------------------------------------
   // Storage, no reset: contents are undefined until first written
   // ------------------------------------------------------------------
   logic [31:0] mem_ff [DEPTH];  // Scratch words

   // Single write port, caller arbitrates
   always_ff @(posedge clk_i) begin
      if (we_i) begin
         mem_ff[waddr_i] <= wdata_i;
      end
   end

   // Two registered read ports, one per accessing side
   always_ff @(posedge clk_i) begin
      rdata_a_o <= mem_ff[raddr_a_i];
      rdata_b_o <= mem_ff[raddr_b_i];
   end
endmodule
`default_nettype wire

// ===== logic/dsr_bank.sv
// Debug status register bank of one tile: oscillator counts and debug state
// ------------------------------------------------------------------
// Overview of operation
// - Four read-only 16-bit ring oscillator counts
// - Oscillator counts survive system reset
// - Memory size readable in bits 31:2
// - Debug entry captures saved status word
// - Status word field layout as listed
// - Bit 9 selects kernel-entry issue, bit 8 read-only
// - Debug entry captures saved program counter
// - Debug entry captures saved stack pointer
// - Thread operand selects remote read thread
// - Register operand selects remote read register
// - Cause code recorded, resets to zero
// - Lowest fired breakpoint index, zero otherwise
// - Causing thread recorded, zero for host
// - Entry data holds address or resource id
// - Stop mask holds threads after debug return
// - Eight scratch words shared with configuration
// ------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module dsr_bank #(
   parameter logic [31:0] MEM_BYTES = 32'h0002_0000,  // On-chip memory size
   parameter int THREADS = 8                          // Logical threads in tile
) (
   input wire logic clk_i,
   input wire logic resetn_i,
   // Processor-status access port
   input wire logic ps_rd_i,
   input wire logic ps_wr_i,
   input wire logic [7:0] ps_addr_i,
   input wire logic [31:0] ps_wdata_i,
   output logic [31:0] ps_rdata_o,
   output logic ps_rvalid_o,
   // Configuration-space scratch access
   input wire logic cfg_rd_i,
   input wire logic cfg_wr_i,
   input wire logic [2:0] cfg_idx_i,
   input wire logic [31:0] cfg_wdata_i,
   output logic [31:0] cfg_rdata_o,
   output logic cfg_rvalid_o,
   // Asynchronous ring oscillator counters
   input wire logic [15:0] osc_count_i [4],
   // Debug state from the core
   input wire logic debug_mode_i,
   input wire logic debug_entry_i,
   input wire logic [10:0] entry_status_i,
   input wire logic [31:0] entry_pc_i,
   input wire logic [31:0] entry_sp_i,
   input wire logic [2:0] entry_cause_i,
   input wire logic [7:0] entry_thread_i,
   input wire logic [3:0] entry_bp_hit_i,
   input wire logic [31:0] entry_addr_i,
   input wire logic [31:0] entry_res_id_i,
   // Controls towards the core
   output logic [7:0] rr_thread_o,
   output logic [4:0] rr_reg_o,
   output logic kern_dual_issue_o,
   output logic [7:0] thread_stop_o
);
   // ------------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------------
   if (THREADS < 1 || THREADS > dsr_pkg::THR_W) begin : g_chk_thr
      $error("THREADS must lie between 1 and 8");
   end
   if (MEM_BYTES[1:0] != 2'h0) begin : g_chk_mem
      $error("MEM_BYTES must be a multiple of four");
   end

   // ------------------------------------------------------------------
   // Oscillator count synchronisers
   // ------------------------------------------------------------------
   logic [15:0] osc_meta_ff [4];  // First stage, read only by second
   logic [15:0] osc_sync_ff [4];  // Settled counts

   // No reset on purpose so the counts survive a system reset;
   // bits are only coherent when software has stopped the oscillator
   for (genvar g = 0; g < dsr_pkg::NUM_OSC; g++) begin : g_osc
      always_ff @(posedge clk_i) begin
         osc_meta_ff[g] <= osc_count_i[g];
         osc_sync_ff[g] <= osc_meta_ff[g];
      end
   end

   // ------------------------------------------------------------------
   // Write decode
   // ------------------------------------------------------------------
   logic dbg_wr;  // Debug-only registers may take this write
   logic scr_hit_w;  // Write lands in scratch window
   logic [2:0] bp_low;  // Lowest fired breakpoint index
   logic [31:0] nxt_entry_data;  // Data captured on entry

   assign dbg_wr = ps_wr_i && debug_mode_i;
   assign scr_hit_w = ps_addr_i >= dsr_pkg::OFF_SCRATCH
                   && ps_addr_i <= dsr_pkg::OFF_SCRATCH_LAST;

   // Priority encode: lowest index wins when several fire
   always_comb begin
      bp_low = 3'h0;
      for (int i = dsr_pkg::NUM_BP - 1; i >= 0; i--) begin
         if (entry_bp_hit_i[i]) begin
            bp_low = 3'(i);
         end
      end
   end

   // Resource id for resource watch, address otherwise
   always_comb begin
      if (entry_cause_i == dsr_pkg::CAUSE_RWATCH) begin
         nxt_entry_data = entry_res_id_i;
      end else begin
         nxt_entry_data = entry_addr_i;
      end
   end

   // ------------------------------------------------------------------
   // Captured debug state
   // ------------------------------------------------------------------
   logic [10:0] ssw_ff;  // Saved status word
   logic [31:0] spc_ff;  // Saved program counter
   logic [31:0] ssp_ff;  // Saved stack pointer
   logic [2:0] cause_ff;  // Cause code
   logic [7:0] cause_thr_ff;  // Causing thread
   logic [1:0] cause_bp_ff;  // Fired breakpoint index
   logic [31:0] entry_data_ff;  // Watch address or resource id

   // Entry capture beats a simultaneous software write
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ssw_ff <= 11'h000;
      end else if (debug_entry_i) begin
         ssw_ff <= entry_status_i;
      end else if (dbg_wr && ps_addr_i == dsr_pkg::OFF_SSW) begin
         // Bit 8 and bit 5 keep their value, only the mask is written
         ssw_ff <= (ssw_ff & ~dsr_pkg::SSW_WR_MASK)
                 | (ps_wdata_i[10:0] & dsr_pkg::SSW_WR_MASK);
      end
   end

   // Program counter and stack pointer
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         spc_ff <= 32'h0000_0000;
         ssp_ff <= 32'h0000_0000;
      end else if (debug_entry_i) begin
         spc_ff <= entry_pc_i;
         ssp_ff <= entry_sp_i;
      end else begin
         if (dbg_wr && ps_addr_i == dsr_pkg::OFF_SPC) begin
            spc_ff <= ps_wdata_i;
         end
         if (dbg_wr && ps_addr_i == dsr_pkg::OFF_SSP) begin
            ssp_ff <= ps_wdata_i;
         end
      end
   end

   // Cause, thread and breakpoint index
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cause_ff <= dsr_pkg::CAUSE_NONE;
         cause_thr_ff <= 8'h00;
         cause_bp_ff <= 2'h0;
      end else if (debug_entry_i) begin
         cause_ff <= entry_cause_i;
         // Host requests carry no thread
         if (entry_cause_i == dsr_pkg::CAUSE_HOST) begin
            cause_thr_ff <= 8'h00;
         end else begin
            cause_thr_ff <= entry_thread_i;
         end
         // Only hardware break and watch causes name an index
         if (entry_cause_i == dsr_pkg::CAUSE_HOST
             || entry_cause_i == dsr_pkg::CAUSE_DEBUG_CALL_INSTRUCTION) begin
            cause_bp_ff <= 2'h0;
         end else begin
            cause_bp_ff <= bp_low[1:0];
         end
      end else if (dbg_wr && ps_addr_i == dsr_pkg::OFF_CAUSE) begin
         cause_ff <= ps_wdata_i[2:0];
         cause_thr_ff <= ps_wdata_i[dsr_pkg::CAUSE_THR_LSB +: dsr_pkg::THR_W];
         cause_bp_ff <= ps_wdata_i[dsr_pkg::CAUSE_BP_LSB +: dsr_pkg::BP_W];
      end
   end

   // Entry data: only watchpoints refresh it
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         entry_data_ff <= 32'h0000_0000;
      end else if (debug_entry_i && (entry_cause_i == dsr_pkg::CAUSE_DWATCH
                   || entry_cause_i == dsr_pkg::CAUSE_RWATCH)) begin
         entry_data_ff <= nxt_entry_data;
      end else if (dbg_wr && ps_addr_i == dsr_pkg::OFF_ENTRY_DATA) begin
         entry_data_ff <= ps_wdata_i;
      end
   end

   // ------------------------------------------------------------------
   // Debugger-written controls
   // ------------------------------------------------------------------
   logic [7:0] rr_thread_ff;  // Remote read thread
   logic [4:0] rr_reg_ff;  // Remote read register
   logic [7:0] stop_mask_ff;  // Threads held outside debug mode
   logic [7:0] thr_valid;  // Threads present in this tile

   assign thr_valid = 8'((9'h001 << THREADS) - 9'h001);

   // Operands and stop mask
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rr_thread_ff <= 8'h00;
         rr_reg_ff <= 5'h00;
         stop_mask_ff <= 8'h00;
      end else begin
         if (dbg_wr && ps_addr_i == dsr_pkg::OFF_RR_THREAD) begin
            rr_thread_ff <= ps_wdata_i[7:0];
         end
         if (dbg_wr && ps_addr_i == dsr_pkg::OFF_RR_REG) begin
            rr_reg_ff <= ps_wdata_i[4:0];
         end
         if (dbg_wr && ps_addr_i == dsr_pkg::OFF_STOP_MASK) begin
            stop_mask_ff <= ps_wdata_i[7:0] & thr_valid;
         end
      end
   end

   // Outputs towards the core, each from its own flop
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rr_thread_o <= 8'h00;
         rr_reg_o <= 5'h00;
         kern_dual_issue_o <= 1'b0;
         thread_stop_o <= 8'h00;
      end else begin
         rr_thread_o <= rr_thread_ff;
         rr_reg_o <= rr_reg_ff;
         kern_dual_issue_o <= ssw_ff[dsr_pkg::SSW_DUAL_SEL];
         // Mask applies only once the debugger has returned
         thread_stop_o <= debug_mode_i ? 8'h00 : stop_mask_ff;
      end
   end

   // ------------------------------------------------------------------
   // Scratch words, shared with the configuration port
   // ------------------------------------------------------------------
   logic scr_we;  // Write into scratch
   logic [2:0] scr_waddr;  // Scratch write index
   logic [31:0] scr_wdata;  // Scratch write data
   logic [31:0] scr_rdata_ps;  // Status-port read word
   logic ps_scr_wr;  // Status-port scratch write

   // Status port wins a same-cycle clash; the config write is dropped
   assign ps_scr_wr = dbg_wr && scr_hit_w;
   assign scr_we = ps_scr_wr || cfg_wr_i;
   assign scr_waddr = ps_scr_wr ? ps_addr_i[2:0] : cfg_idx_i;
   assign scr_wdata = ps_scr_wr ? ps_wdata_i : cfg_wdata_i;

   dsr_scratch_mem #(
      .DEPTH(dsr_pkg::SCR_DEPTH),
      .AW(dsr_pkg::SCR_AW)
   ) u_scratch (
      .clk_i(clk_i),
      .we_i(scr_we),
      .waddr_i(scr_waddr),
      .wdata_i(scr_wdata),
      .raddr_a_i(ps_addr_i[2:0]),
      .raddr_b_i(cfg_idx_i),
      .rdata_a_o(scr_rdata_ps),
      .rdata_b_o(cfg_rdata_o)
   );

   // Config read answers one cycle later with memory data
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cfg_rvalid_o <= 1'b0;
      end else begin
         cfg_rvalid_o <= cfg_rd_i;
      end
   end

   // ------------------------------------------------------------------
   // Read path: two cycles so scratch and registers share one timing
   // ------------------------------------------------------------------
   logic rd_pend_ff;  // Read in flight
   logic [7:0] rd_addr_ff;  // Address of read in flight
   logic [31:0] rd_word;  // Selected word

   // First stage remembers the request
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rd_pend_ff <= 1'b0;
         rd_addr_ff <= 8'h00;
      end else begin
         rd_pend_ff <= ps_rd_i;
         if (ps_rd_i) begin
            rd_addr_ff <= ps_addr_i;
         end
      end
   end

   // Word select; unmapped and reserved bits read zero
   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (rd_addr_ff)
         dsr_pkg::OFF_TILE_CELL_OSC: rd_word = {16'h0000, osc_sync_ff[0]};
         dsr_pkg::OFF_TILE_WIRE_OSC: rd_word = {16'h0000, osc_sync_ff[1]};
         dsr_pkg::OFF_PER_CELL_OSC: rd_word = {16'h0000, osc_sync_ff[2]};
         dsr_pkg::OFF_PER_WIRE_OSC: rd_word = {16'h0000, osc_sync_ff[3]};
         dsr_pkg::OFF_MEMORY_SIZE: rd_word = {MEM_BYTES[31:2], 2'h0};
         dsr_pkg::OFF_SSW: rd_word = {21'h000000, ssw_ff};
         dsr_pkg::OFF_SPC: rd_word = spc_ff;
         dsr_pkg::OFF_SSP: rd_word = ssp_ff;
         dsr_pkg::OFF_RR_THREAD: rd_word = {24'h000000, rr_thread_ff};
         dsr_pkg::OFF_RR_REG: rd_word = {27'h0000000, rr_reg_ff};
         dsr_pkg::OFF_CAUSE: rd_word = {14'h0000, cause_bp_ff, cause_thr_ff,
                                        5'h00, cause_ff};
         dsr_pkg::OFF_ENTRY_DATA: rd_word = entry_data_ff;
         dsr_pkg::OFF_STOP_MASK: rd_word = {24'h000000, stop_mask_ff};
         default: begin
            if (rd_addr_ff >= dsr_pkg::OFF_SCRATCH
                && rd_addr_ff <= dsr_pkg::OFF_SCRATCH_LAST) begin
               rd_word = scr_rdata_ps;
            end
         end
      endcase
   end

   // Second stage drives the port
   always_ff @(posedge clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         ps_rdata_o <= 32'h0000_0000;
         ps_rvalid_o <= 1'b0;
      end else begin
         ps_rvalid_o <= rd_pend_ff;
         if (rd_pend_ff) begin
            ps_rdata_o <= rd_word;
         end
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);

   sequence rd_of(logic [7:0] a);
      ps_rd_i && !ps_wr_i && ps_addr_i == a && !debug_entry_i;
   endsequence
   sequence answer_2;
      ##2 ps_rvalid_o;
   endsequence

   read_latency_a: assert property (ps_rd_i |-> answer_2)
      else $error("read answer not two cycles later");
   osc_upper_zero_a: assert property (rd_of(dsr_pkg::OFF_PER_WIRE_OSC)
      |-> ##2 ps_rdata_o[31:16] == 16'h0000)
      else $error("oscillator reserved bits not zero");
   mem_size_a: assert property (rd_of(dsr_pkg::OFF_MEMORY_SIZE)
      |-> ##2 ps_rdata_o == {MEM_BYTES[31:2], 2'h0})
      else $error("memory size read wrong");
   entry_pc_sp_a: assert property (debug_entry_i
      |=> spc_ff == $past(entry_pc_i) && ssp_ff == $past(entry_sp_i))
      else $error("entry did not capture pc or sp");
   status_cur_ro_a: assert property (dbg_wr && ps_addr_i == dsr_pkg::OFF_SSW
      && !debug_entry_i |=> $stable(ssw_ff[dsr_pkg::SSW_DUAL_CUR]))
      else $error("issue mode bit was written");
   host_no_thread_a: assert property (debug_entry_i
      && entry_cause_i == dsr_pkg::CAUSE_HOST
      |=> cause_thr_ff == 8'h00 && cause_bp_ff == 2'h0)
      else $error("host entry kept thread or index");
   lowest_bp_a: assert property (debug_entry_i && entry_cause_i == dsr_pkg::CAUSE_IBRK
      && entry_bp_hit_i[0] |=> cause_bp_ff == 2'h0)
      else $error("lowest breakpoint not recorded");
   watch_data_a: assert property (debug_entry_i
      && entry_cause_i == dsr_pkg::CAUSE_DWATCH
      |=> entry_data_ff == $past(entry_addr_i))
      else $error("watch address not captured");
   no_write_out_a: assert property (ps_wr_i && !debug_mode_i && !debug_entry_i
      |=> $stable(spc_ff) && $stable(stop_mask_ff))
      else $error("write accepted outside debug mode");
   stop_hold_a: assert property (!debug_mode_i [*2]
      |-> thread_stop_o == $past(stop_mask_ff))
      else $error("stop mask not applied");
   remote_sel_a: assert property (dbg_wr && ps_addr_i == dsr_pkg::OFF_RR_THREAD
      ##1 !(dbg_wr && ps_addr_i == dsr_pkg::OFF_RR_THREAD)
      |=> rr_thread_o == $past(ps_wdata_i[7:0], 2))
      else $error("remote thread select not driven");
endmodule
`default_nettype wire

// ===== dv/dsr_osc_model.sv
// Ring oscillator stand-in: four counters that freeze when stopped
`timescale 1ns/1ps
`default_nettype none
module dsr_osc_model (
   input wire logic clk_i,
   input wire logic run_i,
   output logic [15:0] cnt_o [4]
);
   // ------------------------------
   // Counters
   // ------------------------------
   // Uneven start values so a swapped oscillator shows up
   initial for (int i = 0; i < 4; i++) cnt_o[i] = 16'(i * 16'h1111);
   // No reset input: counts must outlive a system reset
   always @(posedge clk_i) begin
      if (run_i) for (int i = 0; i < 4; i++) cnt_o[i] <= cnt_o[i] + 16'(2 * i + 3);
   end
endmodule
`default_nettype wire

// ===== dv/tb_dsr_bank.sv
// Self-checking bench for the debug status register bank
`timescale 1ns/1ps
`default_nettype none
module tb_dsr_bank;
   // ------------------------------
   // Signals and reference model
   // ------------------------------
   logic clk_i = 0, resetn_i = 0, ps_rd_i = 0, ps_wr_i = 0, cfg_rd_i = 0, cfg_wr_i = 0;
   logic debug_mode_i = 0, debug_entry_i = 0, run = 1, ps_rvalid_o, cfg_rvalid_o;
   logic kern_dual_issue_o;
   logic [2:0] cfg_idx_i = 0, entry_cause_i = 0;
   logic [3:0] entry_bp_hit_i = 0;
   logic [4:0] rr_reg_o;
   logic [7:0] ps_addr_i = 0, entry_thread_i = 0, rr_thread_o, thread_stop_o;
   logic [10:0] entry_status_i = 0;
   logic [15:0] osc_count_i [4];
   logic [31:0] ps_wdata_i = 0, cfg_wdata_i = 0, ps_rdata_o, cfg_rdata_o, rv, e;
   logic [31:0] entry_pc_i = 0, entry_sp_i = 0, entry_addr_i = 0, entry_res_id_i = 0;
   logic [31:0] em [0:39];  // Expected register words by offset
   int n_fail = 0, check_count = 0, seed = 13, cyc = 0;

   dsr_bank dsr_bank_inst (.clk_i, .resetn_i, .ps_rd_i, .ps_wr_i, .ps_addr_i, .ps_wdata_i,
      .ps_rdata_o, .ps_rvalid_o, .cfg_rd_i, .cfg_wr_i, .cfg_idx_i, .cfg_wdata_i, .cfg_rdata_o,
      .cfg_rvalid_o, .osc_count_i, .debug_mode_i, .debug_entry_i, .entry_status_i, .entry_pc_i,
      .entry_sp_i, .entry_cause_i, .entry_thread_i, .entry_bp_hit_i, .entry_addr_i,
      .entry_res_id_i, .rr_thread_o, .rr_reg_o, .kern_dual_issue_o, .thread_stop_o);
   dsr_osc_model dsr_osc_model_inst (.clk_i, .run_i(run), .cnt_o(osc_count_i));

   initial begin
      forever #5 clk_i = ~clk_i;
   end
   // Hang guard: whole run is a few hundred cycles
   always @(posedge clk_i) begin
      cyc++;
      if (cyc > 20000) begin
         n_fail++;
         end_sim();
      end
   end
   // ------------------------------
   // Tasks
   // ------------------------------
   task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
      check_count++;
      if (g !== x) begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", nm, x, g);
      end
   endtask
   // Bits software may change; zero means read-only or unmapped
   function automatic logic [31:0] wm(input logic [7:0] a);
      case (a)
         8'h10: wm = 32'h0000_06DF;
         8'h11, 8'h12, 8'h16: wm = 32'hFFFF_FFFF;
         8'h13, 8'h18: wm = 32'h0000_00FF;
         8'h14: wm = 32'h0000_001F;
         8'h15: wm = 32'h0003_FF07;
         default: wm = (a >= 8'h20 && a <= 8'h27) ? 32'hFFFF_FFFF : 32'h0;
      endcase
   endfunction
   task automatic rst();
      resetn_i = 0;
      repeat (4) @(posedge clk_i);
      #1 resetn_i = 1;
      for (int i = 16; i < 25; i++) em[i] = 0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i) #1 {ps_wr_i, ps_addr_i, ps_wdata_i} = {1'b1, a, d};
      if (debug_mode_i) em[a] = (em[a] & ~wm(a)) | (d & wm(a));
      @(posedge clk_i) #1 ps_wr_i = 0;
   endtask
   // Read, wait a bounded time for the answer strobe, compare
   task automatic rc(input logic [7:0] a);
      @(posedge clk_i) #1 {ps_rd_i, ps_addr_i} = {1'b1, a};
      @(posedge clk_i) #1 ps_rd_i = 0;
      for (int i = 0; i < 4 && ps_rvalid_o !== 1'b1; i++) @(posedge clk_i) #1;
      chk($sformatf("reg %h", a), em[a], ps_rvalid_o === 1'b1 ? ps_rdata_o : ~em[a]);
   endtask
   task automatic outs();
      repeat (3) @(posedge clk_i);
      chk("thread sel", {24'h0, em[19][7:0]}, {24'h0, rr_thread_o});
      chk("reg sel", {27'h0, em[20][4:0]}, {27'h0, rr_reg_o});
      chk("dual issue", {31'h0, em[16][9]}, {31'h0, kern_dual_issue_o});
      chk("stop", debug_mode_i ? 32'h0 : em[24], {24'h0, thread_stop_o});
   endtask
   task automatic ent(input logic [2:0] c);
      @(posedge clk_i) #1 debug_entry_i = 1;
      entry_status_i = 11'($random(seed)) & 11'h7DF;
      {entry_pc_i, entry_sp_i} = {$random(seed), $random(seed)};
      {entry_addr_i, entry_res_id_i} = {$random(seed), $random(seed)};
      {entry_thread_i, entry_bp_hit_i} = 12'($random(seed));
      entry_cause_i = c;
      {em[16], em[17], em[18]} = {21'h0, entry_status_i, entry_pc_i, entry_sp_i};
      e = 0;
      for (int i = 3; i >= 0; i--) if (entry_bp_hit_i[i] && c > 2) e = i;
      em[21] = {14'h0, e[1:0], (c == 1) ? 8'h0 : entry_thread_i, 5'h0, c};
      if (c == 4) em[22] = entry_addr_i;
      if (c == 5) em[22] = entry_res_id_i;
      @(posedge clk_i) #1 debug_entry_i = 0;
   endtask
   task automatic end_sim();
      $display("comparisons %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // ------------------------------
   // Main sequence
   // ------------------------------
   initial begin
      for (int i = 0; i < 40; i++) em[i] = 0;
      em[12] = 32'h0002_0000;
      rst();
      // Stop oscillators and let them settle before reading
      @(posedge clk_i) #1 run = 0;
      repeat (12) @(posedge clk_i);
      for (int i = 0; i < 4; i++) em[7 + i] = {16'h0, osc_count_i[i]};
      for (int a = 7; a < 13; a++) rc(8'(a));
      rst();
      for (int a = 7; a < 11; a++) rc(8'(a));
      $display("oscillator and size test done");
      // Debug mode writes land, then writes outside it are ignored
      for (int p = 0; p < 2; p++) begin
         @(posedge clk_i) #1 debug_mode_i = (p == 0);
         for (int a = 16; a < 40; a++) wr(8'(a), $random(seed));
         for (int a = 16; a < 40; a++) rc(8'(a));
         outs();
      end
      $display("write access test done");
      // Every entry cause, then the captured words
      @(posedge clk_i) #1 debug_mode_i = 1;
      for (int c = 1; c < 6; c++) begin
         ent(3'(c));
         for (int a = 16; a < 23; a++) rc(8'(a));
         outs();
      end
      $display("debug entry test done");
      // Configuration side shares the scratch words
      @(posedge clk_i) #1 {cfg_wr_i, cfg_idx_i, cfg_wdata_i} = {1'b1, 3'h5, 32'h1234_ABCD};
      em[37] = 32'h1234_ABCD;
      @(posedge clk_i) #1 {cfg_wr_i, cfg_rd_i, cfg_idx_i} = {1'b0, 1'b1, 3'h2};
      @(posedge clk_i) #1 cfg_rd_i = 0;
      chk("cfg valid", 32'h1, {31'h0, cfg_rvalid_o});
      chk("cfg data", em[34], cfg_rdata_o);
      rc(8'h25);
      rst();
      rc(8'h15);
      $display("scratch and reset test done");
      end_sim();
   end
endmodule
`default_nettype wire
